// ---- inc/ang_pkg.sv ----
// Constants, field layout and carrier types for the auto-negotiation
// next page and expansion status registers.
// Assumes a 5-bit management register address space and one 100 MHz clock.
//
// Overview of operation
// R1: Bit 13 flags message or unformatted page
// R2: Bit 12 shows partner can comply
// R3: Bit 11 is inverse of previous toggle
// R4: Bits 10:0 hold partner code, reset zero
// R5: Expansion bits 15:5 ignore writes, read zero
// R6: Expansion bit 4 shows parallel detection fault
// R7: Expansion bit 3 shows partner next page ability
// R8: Expansion bit 2 fixed at one
// R9: Expansion bit 1 set on page, read clears
// R10: Expansion bit 0 shows partner negotiation ability
// R11: Bit 15 shows partner wants more pages
// R12: Bit 14 partner acknowledge, hardware driven only
// R13: Whole word updates with page-received flag
package ang_pkg;

    // Register offsets
    localparam logic [4:0] OFS_NP_WORD = 5'h05;
    localparam logic [4:0] OFS_EXPANSION = 5'h06;
    localparam logic [4:0] OFS_IRQ_STATUS = 5'h10;
    localparam logic [4:0] OFS_IRQ_MASK = 5'h11;

    // Expansion status field positions
    localparam int EXP_RSV_LSB = 5;
    localparam int EXP_PDF_BIT = 4;
    localparam int EXP_LP_NP_BIT = 3;
    localparam int EXP_LOCAL_MULTI_PAGE_CAPABLE_BIT = 2;
    localparam int EXP_PAGE_RX_BIT = 1;
    localparam int EXP_LP_AN_BIT = 0;

    // Interrupt status and mask field positions
    localparam int IRQ_PAGE_BIT = 0;
    localparam int IRQ_PDF_BIT = 1;
    localparam int IRQ_W = 2;

    // Reset values
    localparam logic [15:0] NP_WORD_RST = 16'h0000;
    localparam logic [10:0] CODE_RST = 11'h000;
    localparam logic LOCAL_LOCAL_MULTI_PAGE_CAPABLE = 1'b1;
    localparam logic [1:0] IRQ_MASK_RST = 2'h0;
    localparam logic [15:0] RDATA_RST = 16'h0000;

    // Next page code word as received from the partner, bit 15 first
    typedef struct packed {
        logic more_pages_wanted;
        logic partner_ack;
        logic message_page_flag;
        logic comply_ack;
        logic toggle;
        logic [10:0] code;
    } ang_np_word_t;

    // Level status from the arbitration logic
    typedef struct packed {
        logic parallel_detect_fault;
        logic partner_multi_page_capable;
        logic partner_negotiation_capable;
    } ang_link_status_t;

endpackage

// ---- rtl/ang_irq_bank.sv ----
// Sticky event status with write-one-to-clear, a mask and one level output.
// Assumes one synchronous clock and the event pulses in that domain.
`timescale 1ns/100ps
`default_nettype none
module ang_irq_bank #(
    parameter int W = 2
) (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [W-1:0] evt,
    input wire logic wr_status,
    input wire logic wr_mask,
    input wire logic [W-1:0] wdata,
    output logic [W-1:0] status,
    output logic [W-1:0] mask,
    output logic irq
);

    logic [W-1:0] status_reg; // Sticky event bits
    logic [W-1:0] mask_reg; // Enable per event
    logic [W-1:0] status_next; // Next sticky state
    logic [W-1:0] mask_next; // Next mask state

    // Per bit: an event wins over a clear in the same cycle
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            assign status_next[i] = evt[i] | (status_reg[i] & ~(wr_status & wdata[i]));
        end
    endgenerate

    // Mask loads on its own write
    assign mask_next = wr_mask ? wdata : mask_reg;

    // Status and mask flops
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            status_reg <= '0;
            mask_reg <= W'(ang_pkg::IRQ_MASK_RST);
        end else begin
            status_reg <= status_next;
            mask_reg <= mask_next;
        end
    end

    // Level output while any unmasked bit stands
    assign status = status_reg;
    assign mask = mask_reg;
    assign irq = |(status_reg & mask_reg);

endmodule
`default_nettype wire

// ---- rtl/ang_status_regs.sv ----
// Received next page word and expansion status registers, with an event
// interrupt bank, reached over a plain strobe register port.
// Assumes the arbitration logic delivers page words and levels synchronously.
//
// Chosen here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module ang_status_regs (
    input wire logic ref_clk,
    input wire logic rstn,
    input wire logic [4:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire logic page_accept,
    input wire ang_pkg::ang_np_word_t page_word,
    input wire ang_pkg::ang_link_status_t link_status,
    output logic irq
);

    // Stored partner word and status flops
    ang_pkg::ang_np_word_t np_word_reg; // Last accepted partner word
    ang_pkg::ang_np_word_t np_word_next; // Its next value
    logic page_rx_reg; // Page received, cleared on read
    logic page_rx_next; // Its next value
    logic pdf_reg; // Parallel detection fault level
    logic lp_np_reg; // Partner next page ability level
    logic lp_an_reg; // Partner negotiation ability level
    logic pdf_prev_reg; // Fault level one cycle back, for edge event
    logic [15:0] rdata_reg; // Read answer
    logic [15:0] rdata_next; // Its next value

    // Address decode
    wire hit_np_word = (reg_addr == ang_pkg::OFS_NP_WORD);
    wire hit_exp = (reg_addr == ang_pkg::OFS_EXPANSION);
    wire hit_irq_status = (reg_addr == ang_pkg::OFS_IRQ_STATUS);
    wire hit_irq_mask = (reg_addr == ang_pkg::OFS_IRQ_MASK);
    // Qualified strobes; a write to the two status words decodes to nothing
    wire rd_exp = reg_rd & hit_exp;
    wire wr_irq_status = reg_wr & hit_irq_status;
    wire wr_irq_mask = reg_wr & hit_irq_mask;

    // Interrupt bank wiring; the edge detector starts low like an idle
    // fault level, so leaving reset never raises a false fault event
    wire pdf_rise = pdf_reg & ~pdf_prev_reg;
    wire [ang_pkg::IRQ_W-1:0] irq_evt;
    wire [ang_pkg::IRQ_W-1:0] irq_status;
    wire [ang_pkg::IRQ_W-1:0] irq_mask;
    assign irq_evt[ang_pkg::IRQ_PAGE_BIT] = page_accept;
    assign irq_evt[ang_pkg::IRQ_PDF_BIT] = pdf_rise;

    // Whole partner word loads only on an accepted page
    assign np_word_next = page_accept ? page_word : np_word_reg; // R13 R1 R2 R3 R4 R11 R12

    // Received flag: a new page wins over the read that would clear it,
    // so software never misses a page that lands during its own read
    assign page_rx_next = page_accept | (page_rx_reg & ~rd_exp); // R9 R13

    // Expansion word assembly, reserved bits tied to zero
    // Bit 2 is a constant: this end can always send further pages
    wire [15:0] exp_word;
    assign exp_word[15:ang_pkg::EXP_RSV_LSB] = '0; // R5
    assign exp_word[ang_pkg::EXP_PDF_BIT] = pdf_reg; // R6
    assign exp_word[ang_pkg::EXP_LP_NP_BIT] = lp_np_reg; // R7
    assign exp_word[ang_pkg::EXP_LOCAL_MULTI_PAGE_CAPABLE_BIT] = ang_pkg::LOCAL_LOCAL_MULTI_PAGE_CAPABLE; // R8
    assign exp_word[ang_pkg::EXP_PAGE_RX_BIT] = page_rx_reg; // R9
    assign exp_word[ang_pkg::EXP_LP_AN_BIT] = lp_an_reg; // R10

    // Interrupt words, upper bits zero
    wire [15:0] irq_status_word = {{(16 - ang_pkg::IRQ_W){1'b0}}, irq_status};
    wire [15:0] irq_mask_word = {{(16 - ang_pkg::IRQ_W){1'b0}}, irq_mask};

    // Read mux; unmapped addresses answer zero
    wire [15:0] rd_mux = hit_np_word ? 16'(np_word_reg) :
                         hit_exp ? exp_word :
                         hit_irq_status ? irq_status_word :
                         hit_irq_mask ? irq_mask_word : 16'h0000;

    // Read data stands only in the cycle after the strobe
    // Zero at all other times, so a late sample never takes a stale word
    assign rdata_next = reg_rd ? rd_mux : 16'h0000;

    // Partner word and received flag; software writes never reach them
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            np_word_reg <= ang_pkg::NP_WORD_RST; // R4
            page_rx_reg <= 1'b0;
        end else begin
            np_word_reg <= np_word_next;
            page_rx_reg <= page_rx_next;
        end
    end

    // Level status capture from the arbitration logic
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            pdf_reg <= 1'b0;
            lp_np_reg <= 1'b0;
            lp_an_reg <= 1'b0;
            pdf_prev_reg <= 1'b0;
        end else begin
            pdf_reg <= link_status.parallel_detect_fault; // R6
            lp_np_reg <= link_status.partner_multi_page_capable; // R7
            lp_an_reg <= link_status.partner_negotiation_capable; // R10
            pdf_prev_reg <= pdf_reg;
        end
    end

    // Read data register
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rdata_reg <= ang_pkg::RDATA_RST;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // Read answer straight from its flop
    assign reg_rdata = rdata_reg;

    // Sticky events, mask and interrupt output
    // Bit 0 is the page event, bit 1 the rising edge of the fault level
    ang_irq_bank #(
        .W(ang_pkg::IRQ_W)
    ) u_irq (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .evt(irq_evt),
        .wr_status(wr_irq_status),
        .wr_mask(wr_irq_mask),
        .wdata(reg_wdata[ang_pkg::IRQ_W-1:0]),
        .status(irq_status),
        .mask(irq_mask),
        .irq(irq)
    );

    // Checks on the register behaviour; all run on the register clock and
    // stand down while reset is held, so the flops' reset values are not
    // compared against a history taken before or during reset
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    // A page accepted, one idle cycle, then the expansion word read
    sequence s_page_then_read;
        page_accept ##1 (!page_accept && !rd_exp)
            ##1 (rd_exp && !page_accept);
    endsequence

    // The fault level seen low, then high
    sequence s_pdf_rise;
        !link_status.parallel_detect_fault ##1 link_status.parallel_detect_fault;
    endsequence

    // A read of the next page word
    sequence s_np_read;
        reg_rd && hit_np_word;
    endsequence

    a_page_rx_set: assert property ( // R9
        page_accept |=> page_rx_reg)
        else $error("page received flag not set after accept");

    a_page_rx_clear: assert property ( // R9
        s_page_then_read |=> !page_rx_reg && reg_rdata[ang_pkg::EXP_PAGE_RX_BIT] == 1'b1)
        else $error("page received flag not cleared by read or not reported");

    a_page_rx_hold: assert property ( // R9
        (page_rx_reg && !rd_exp) |=> page_rx_reg)
        else $error("page received flag lost without a read");

    a_word_with_flag: assert property ( // R13
        page_accept |=> (np_word_reg == $past(page_word)) && page_rx_reg)
        else $error("partner word and flag not updated together");

    a_word_stable: assert property ( // R12
        !page_accept |=> $stable(np_word_reg))
        else $error("partner word changed without accept");

    a_np_fields_read: assert property ( // R1
        s_np_read |=> reg_rdata[13] == $past(np_word_reg.message_page_flag)
            && reg_rdata[12] == $past(np_word_reg.comply_ack)
            && reg_rdata[11] == $past(np_word_reg.toggle))
        else $error("message, comply or toggle bit misreported");

    a_np_code_read: assert property ( // R4
        s_np_read |=> reg_rdata[10:0] == $past(np_word_reg.code)
            && reg_rdata[15] == $past(np_word_reg.more_pages_wanted))
        else $error("code field or more pages bit misreported");

    a_exp_reserved: assert property ( // R5
        (reg_rd && hit_exp) |=> reg_rdata[15:5] == 11'h000
            && reg_rdata[ang_pkg::EXP_LOCAL_MULTI_PAGE_CAPABLE_BIT] == 1'b1)
        else $error("reserved bits nonzero or local ability not set");

    a_exp_levels: assert property ( // R6
        (reg_rd && hit_exp) ##0 (link_status == $past(link_status)) |=>
            reg_rdata[ang_pkg::EXP_PDF_BIT] == $past(link_status.parallel_detect_fault)
            && reg_rdata[ang_pkg::EXP_LP_NP_BIT]
                == $past(link_status.partner_multi_page_capable)
            && reg_rdata[ang_pkg::EXP_LP_AN_BIT]
                == $past(link_status.partner_negotiation_capable))
        else $error("expansion level bits do not follow arbitration");

    a_rdata_window: assert property ( // R5
        !reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data present without a read strobe");

    // A page event with its mask bit set raises the interrupt line
    a_irq_level: assert property (
        (page_accept && irq_mask[ang_pkg::IRQ_PAGE_BIT] && !wr_irq_mask) |=> irq)
        else $error("interrupt output not raised by unmasked page event");

    // No mask bit set means no interrupt in the next cycle
    a_irq_quiet: assert property (
        (irq_mask == '0 && !wr_irq_mask) |=> !irq)
        else $error("interrupt output raised with every event masked");

    // A page event wins over a clearing write in the same cycle
    a_irq_evt_wins: assert property (
        (page_accept && wr_irq_status && reg_wdata[ang_pkg::IRQ_PAGE_BIT])
            |=> irq_status[ang_pkg::IRQ_PAGE_BIT])
        else $error("page event lost to a same cycle clear");

    // Writing a one clears the page event bit when no event meets it
    a_irq_w1c: assert property (
        (wr_irq_status && reg_wdata[ang_pkg::IRQ_PAGE_BIT] && !page_accept)
            |=> !irq_status[ang_pkg::IRQ_PAGE_BIT])
        else $error("page event bit not cleared by writing one");

    // A rising fault level reaches the event bank two cycles on
    a_pdf_event: assert property ( // R6
        s_pdf_rise |=> ##1 irq_status[ang_pkg::IRQ_PDF_BIT])
        else $error("fault rise did not set its event bit");

    // An accept meeting a clearing read keeps the flag; the read shows the old value
    a_page_rx_race: assert property ( // R9
        (page_accept && rd_exp) |=> page_rx_reg
            && reg_rdata[ang_pkg::EXP_PAGE_RX_BIT] == $past(page_rx_reg))
        else $error("page received flag lost to a same cycle read");

    // A software write to the expansion word leaves the flag alone
    a_exp_write_ignored: assert property ( // R5
        (reg_wr && !reg_rd && hit_exp && !page_accept)
            |=> page_rx_reg == $past(page_rx_reg))
        else $error("write to expansion word changed the received flag");

    // A software write to the partner word leaves it alone
    a_np_hold_write: assert property ( // R12
        (reg_wr && hit_np_word && !page_accept) |=> $stable(np_word_reg))
        else $error("write to partner word changed it");

    // The acknowledge bit reads back as last captured
    a_np_ack_read: assert property ( // R12
        s_np_read |=> reg_rdata[14] == $past(np_word_reg.partner_ack))
        else $error("partner acknowledge bit misreported");

    // The whole partner word reads back as one
    a_np_whole_read: assert property ( // R4
        s_np_read |=> reg_rdata == 16'($past(np_word_reg)))
        else $error("partner word misreported");

    // The received flag reads back as it stood at the read
    a_rx_flag_read: assert property ( // R9
        rd_exp |=> reg_rdata[ang_pkg::EXP_PAGE_RX_BIT] == $past(page_rx_reg))
        else $error("page received flag misreported");

    // Without a page the flag stays clear
    a_flag_stays_clear: assert property ( // R9
        (!page_rx_reg && !page_accept) |=> !page_rx_reg)
        else $error("page received flag set without a page");

    // Unmapped addresses answer zero
    a_unmapped_read: assert property (
        (reg_rd && !hit_np_word && !hit_exp && !hit_irq_status && !hit_irq_mask)
            |=> reg_rdata == 16'h0000)
        else $error("unmapped read returned nonzero data");

    // Event status reads back zero-extended
    a_status_read: assert property (
        (reg_rd && hit_irq_status) |=> reg_rdata == 16'($past(irq_status)))
        else $error("event status misreported");

    // Mask reads back zero-extended
    a_mask_read: assert property (
        (reg_rd && hit_irq_mask) |=> reg_rdata == 16'($past(irq_mask)))
        else $error("event mask misreported");

    // A mask write loads the written bits
    a_mask_write: assert property (
        wr_irq_mask |=> irq_mask == $past(reg_wdata[ang_pkg::IRQ_W-1:0]))
        else $error("event mask not loaded by its write");

    // No page event, no page status bit
    a_page_quiet: assert property (
        (!irq_status[ang_pkg::IRQ_PAGE_BIT] && !page_accept)
            |=> !irq_status[ang_pkg::IRQ_PAGE_BIT])
        else $error("page event bit set without a page");

    // No fault rise, no fault status bit
    a_pdf_quiet: assert property (
        (!irq_status[ang_pkg::IRQ_PDF_BIT] && !pdf_rise)
            |=> !irq_status[ang_pkg::IRQ_PDF_BIT])
        else $error("fault event bit set without a rise");

endmodule
`default_nettype wire

// ---- test/ang_lp_model.sv ----
// Far-side model: the arbitration logic handing over pages and levels.
// Assumes it shares the one register clock with the status block.
`timescale 1ns/100ps
`default_nettype none
module ang_lp_model (
    input wire logic ref_clk,
    output logic page_accept,
    output ang_pkg::ang_np_word_t page_word,
    output ang_pkg::ang_link_status_t link_status
);
    // Idle: no accept, all levels low
    initial begin
        page_accept = 1'b0;
        page_word = 16'h0000;
        link_status = 3'h0;
    end
    // One-cycle accept with the whole word; word lines change after it
    task automatic send(input logic [15:0] w);
        @(posedge ref_clk);
        page_accept <= 1'b1;
        page_word <= w;
        @(posedge ref_clk);
        page_accept <= 1'b0;
        page_word <= ~w;
    endtask
    // New fault and ability levels
    task automatic levels(input logic [2:0] s);
        @(posedge ref_clk);
        link_status <= s;
    endtask
endmodule
`default_nettype wire

// ---- test/tb.sv ----
// Self-checking bench for the next page and expansion status registers.
// Assumes the far side is the partner model and a strobe register port.
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic ref_clk;
    logic rstn;
    logic [4:0] reg_addr;
    logic [15:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [15:0] reg_rdata;
    logic page_accept;
    logic irq;
    ang_pkg::ang_np_word_t page_word;
    ang_pkg::ang_link_status_t link_status;
    int n_fail = 0;
    int cmp_count = 0;
    logic [15:0] pages [2] = '{16'hA555, 16'h5AAA};
    logic [2:0] lv [4] = '{3'h4, 3'h2, 3'h1, 3'h7};
    // Device under test
    ang_status_regs i_dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .page_accept(page_accept), .page_word(page_word),
        .link_status(link_status), .irq(irq));
    // Arbitration side
    ang_lp_model i_lp (.ref_clk(ref_clk), .page_accept(page_accept),
        .page_word(page_word), .link_status(link_status));
    // 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Verdict and end of run
    task automatic final_report();
        if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // Compare and report
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // One-cycle write
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // One-cycle read; data looked at in the following cycle only
    task automatic rd(input logic [4:0] a, input logic [15:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp);
    endtask
    // Values straight after reset
    task automatic t_reset();
        rd(5'h05, 16'h0000);
        rd(5'h06, 16'h0004);
        chk({15'h0, irq}, 16'h0000);
    endtask
    // Pages with every field flipped; flag set once, cleared by a read
    task automatic t_page();
        foreach (pages[i]) begin
            i_lp.send(pages[i]);
            rd(5'h06, 16'h0006);
            rd(5'h05, pages[i]);
            rd(5'h06, 16'h0004);
        end
    endtask
    // Each level on its own bit, then all together
    task automatic t_levels();
        foreach (lv[i]) begin
            i_lp.levels(lv[i]);
            rd(5'h06, {11'h0, lv[i][2], lv[i][1], 2'b10, lv[i][0]});
        end
        rd(5'h10, 16'h0003);
        i_lp.levels(3'h0);
    endtask
    // Software writes leave both registers untouched
    task automatic t_writes();
        wr(5'h06, 16'hFFFF);
        wr(5'h05, 16'hFFFF);
        rd(5'h06, 16'h0004);
        rd(5'h05, 16'h5AAA);
        rd(5'h1F, 16'h0000);
    endtask
    // Page event raises, mask holds back, write of one clears
    task automatic t_irq();
        wr(5'h10, 16'h0003);
        wr(5'h11, 16'h0001);
        rd(5'h11, 16'h0001);
        i_lp.send(16'h2001);
        #1;
        chk({15'h0, irq}, 16'h0001);
        rd(5'h10, 16'h0001);
        wr(5'h10, 16'h0001);
        #1;
        chk({15'h0, irq}, 16'h0000);
        wr(5'h11, 16'h0000);
        i_lp.send(16'h0001);
        #1;
        chk({15'h0, irq}, 16'h0000);
        rd(5'h10, 16'h0001);
        rd(5'h05, 16'h0001);
    endtask
    // Accept meets clearing read, then page event meets clearing write
    task automatic t_race();
        fork
            i_lp.send(16'h0002);
            rd(5'h06, 16'h0006);
        join
        rd(5'h06, 16'h0006);
        rd(5'h06, 16'h0004);
        fork
            i_lp.send(16'h0003);
            wr(5'h10, 16'h0001);
        join
        rd(5'h10, 16'h0001);
        rd(5'h05, 16'h0003);
    endtask
    // Reset in mid-run brings every register back to its reset value
    task automatic t_midreset();
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        rd(5'h05, 16'h0000);
        rd(5'h06, 16'h0004);
        rd(5'h10, 16'h0000);
        rd(5'h11, 16'h0000);
        chk({15'h0, irq}, 16'h0000);
    endtask
    // Main sequence
    initial begin
        rstn = 1'b0;
        reg_addr = 5'h00;
        reg_wdata = 16'h0000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (8) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_page();
        t_levels();
        t_writes();
        t_irq();
        t_race();
        t_midreset();
        final_report();
    end
    // Watchdog against a hang
    initial begin
        #100000;
        n_fail++;
        final_report();
    end
endmodule
`default_nettype wire
